// ===== dv/acr_host_model.sv
`timescale 1ns/10ps
// Host side of the configuration port. The serial clock rests low between frames,
// and the data line shows the inverse bit once its hold time is over.
module acr_host_model (
  input  wire logic clk_i,
  output logic      serial_clock_o,
  output logic      serial_data_o,
  output logic      select_n_o
);
  initial begin
    serial_clock_o = 1'b0;
    serial_data_o  = 1'b1;
    select_n_o     = 1'b1;
  end

  // Each bit is set up while the clock is low and held across its rising edge.
  task automatic put_bit(input logic b);
    @(negedge clk_i) serial_data_o = b;
    select_n_o = 1'b0;
    @(negedge clk_i) serial_clock_o = 1'b1;
    @(negedge clk_i);
    @(negedge clk_i) serial_clock_o = 1'b0;
    serial_data_o = ~b;
  endtask

  // Address byte first, then data, most significant bit first.
  task automatic send(input logic [23:0] w, input logic last);
    for (int i = 23; i >= 0; i--) put_bit(w[i]);
    if (last) @(negedge clk_i) select_n_o = 1'b1;
  endtask

  // Dropping select halfway must throw away the bits already shifted in.
  task automatic abort(input logic [11:0] w);
    for (int i = 11; i >= 0; i--) put_bit(w[i]);
    @(negedge clk_i) select_n_o = 1'b1;
  endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk_i, reset_i, serial_clock_i, serial_config_input_i, serial_config_select_n_i;
  logic powerdown_input_pin_i, sample_strobe_i, single_channel_nap_o, chip_sleep_o;
  logic full_power_off_request_o, powerdown_pin_level_o, term_enable_o;
  logic single_polarity_swap_o, out_valid_o;
  logic [1:0] dual_channel_nap_o, powerdown_pin_function_o, dual_polarity_swap_o;
  logic [2:0] bit_clock_drive_o, frame_clock_drive_o, data_drive_o;
  logic [2:0] bit_clock_term_o, frame_clock_term_o, data_term_o;
  logic [3:0] quad_channel_nap_o, quad_polarity_swap_o, quad_gain_lane_one_o;
  logic [3:0] quad_gain_lane_two_o, quad_gain_lane_three_o, quad_gain_lane_four_o;
  logic [7:0] conv_data_i, first_pattern_code_o, second_pattern_code_o, out_word_o;
  logic [7:0] addrs [7] = '{8'h0F, 8'h11, 8'h12, 8'h24, 8'h26, 8'h27, 8'h2A};
  // Images left by the last row written to each address, in the order of addrs.
  logic [15:0] snap [7] = '{16'h0000, 16'h073F, 16'h4125, 16'h0035, 16'h5A00, 16'hFF00,
    16'hFFFF};
  // Address, data written, register image expected.
  logic [39:0] rows [12] = '{40'h0F_FFFF_0F7F, 40'h11_FFFF_073F, 40'h12_FFFF_473F,
    40'h24_FFFF_007F, 40'h26_FFFF_FF00, 40'h27_FFFF_FF00, 40'h2A_FFFF_FFFF,
    40'h0F_0200_0200, 40'h0F_0000_0000, 40'h12_4125_4125, 40'h26_5A12_5A00,
    40'h24_0035_0035};
  int bad_count = 0;
  int n_compared = 0;

  acr_config_bank u_acr_config_bank (
    .clk_i, .reset_i, .serial_clock_i, .serial_config_input_i, .serial_config_select_n_i,
    .powerdown_input_pin_i, .conv_data_i, .sample_strobe_i, .quad_channel_nap_o,
    .dual_channel_nap_o, .single_channel_nap_o, .chip_sleep_o, .full_power_off_request_o,
    .powerdown_pin_function_o, .powerdown_pin_level_o, .bit_clock_drive_o,
    .frame_clock_drive_o, .data_drive_o, .term_enable_o, .bit_clock_term_o,
    .frame_clock_term_o, .data_term_o, .quad_polarity_swap_o, .dual_polarity_swap_o,
    .single_polarity_swap_o, .first_pattern_code_o, .second_pattern_code_o,
    .quad_gain_lane_one_o, .quad_gain_lane_two_o, .quad_gain_lane_three_o,
    .quad_gain_lane_four_o, .out_word_o, .out_valid_o);
  acr_host_model u_host (.clk_i, .serial_clock_o(serial_clock_i),
    .serial_data_o(serial_config_input_i), .select_n_o(serial_config_select_n_i));

  always #2.5 clk_i = ~clk_i;

  // Rebuilds a register image from the outputs, so unassigned bits must read zero.
  function automatic logic [15:0] img(input logic [7:0] a);
    case (a)
      8'h0F: img = {4'h0, powerdown_pin_function_o, full_power_off_request_o, chip_sleep_o,
                    1'h0, single_channel_nap_o, dual_channel_nap_o, quad_channel_nap_o};
      8'h11: img = {5'h00, data_drive_o, 2'h0, frame_clock_drive_o, bit_clock_drive_o};
      8'h12: img = {1'h0, term_enable_o, 3'h0, data_term_o, 2'h0, frame_clock_term_o,
                    bit_clock_term_o};
      8'h24: img = {9'h000, single_polarity_swap_o, dual_polarity_swap_o,
                    quad_polarity_swap_o};
      8'h26: img = {first_pattern_code_o, 8'h00};
      8'h27: img = {second_pattern_code_o, 8'h00};
      default: img = {quad_gain_lane_four_o, quad_gain_lane_three_o, quad_gain_lane_two_o,
                      quad_gain_lane_one_o};
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    n_compared++;
    if (seen !== expected) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic all_regs(input logic use_snap);
    for (int k = 0; k < 7; k++) check(img(addrs[k]), use_snap ? snap[k] : 16'h0000);
  endtask

  // Strobe stays high between calls, so successive calls give back-to-back words.
  task automatic strobe(input logic [7:0] d, input logic [7:0] e);
    sample_strobe_i = 1'b1;
    conv_data_i = d;
    @(negedge clk_i);
    check(out_word_o, e);
    check(out_valid_o, 1'b1);
  endtask

  task automatic stop;
    sample_strobe_i = 1'b0;
    @(negedge clk_i);
    check(out_valid_o, 1'b0);
  endtask

  task automatic summarize;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    summarize();
  end

  initial begin
    clk_i = 1'b0;
    reset_i = 1'b1;
    powerdown_input_pin_i = 1'b0;
    sample_strobe_i = 1'b0;
    conv_data_i = 8'h00;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    all_regs(1'b0);
    powerdown_input_pin_i = 1'b1;
    @(negedge clk_i);
    check(powerdown_pin_level_o, 1'b1);
    for (int r = 0; r < 12; r++) begin
      u_host.send(rows[r][39:16], 1'b1);
      check(img(rows[r][39:32]), rows[r][15:0]);
    end
    u_host.send(24'h13FFFF, 1'b1);
    u_host.send(24'h00FFFE, 1'b1);
    all_regs(1'b1);
    u_host.send(24'h000001, 1'b1);
    all_regs(1'b0);
    u_host.send(24'h0F0005, 1'b1);
    check(img(8'h0F), 16'h0005);
    u_host.abort(12'hFFF);
    u_host.send(24'h0F0003, 1'b1);
    check(img(8'h0F), 16'h0003);
    u_host.send(24'h110123, 1'b0);
    u_host.send(24'h2ABEEF, 1'b1);
    check(img(8'h11), 16'h0123);
    check(img(8'h2A), 16'hBEEF);
    u_host.send(24'h250040, 1'b1);
    for (int i = 0; i < 257; i++) strobe(8'h00, i[7:0]);
    stop();
    u_host.send(24'h26C300, 1'b1);
    u_host.send(24'h273C00, 1'b1);
    u_host.send(24'h250020, 1'b1);
    for (int i = 0; i < 4; i++) strobe(8'h00, i[0] ? 8'h3C : 8'hC3);
    stop();
    u_host.send(24'h250010, 1'b1);
    for (int i = 0; i < 2; i++) strobe(8'h00, 8'hC3);
    stop();
    u_host.send(24'h250000, 1'b1);
    strobe(8'h5A, 8'h5A);
    stop();
    u_host.send(24'h250040, 1'b1);
    strobe(8'h00, 8'h00);
    stop();
    reset_i = 1'b1;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    all_regs(1'b0);
    check(out_word_o, 16'h0000);
    check(out_valid_o, 1'b0);
    summarize();
  end
endmodule

// ===== src/acr_config_bank.sv
`timescale 1ns/10ps
`include "acr_consts.svh"
// Notes on behaviour
// RQ1: Soft reset bit restores defaults, self-clears.
// RQ2: Register 0x0F holds per-mode channel sleep bits.
// RQ3: Bits D11..D10 choose power-down pin function.
// RQ4: Register 0x11 holds three drive-current fields.
// RQ5: Bit D14 of 0x12 enables termination.
// RQ6: Register 0x12 holds three termination values.
// RQ7: Register 0x24 holds per-mode polarity swap bits.
// RQ8: Ramp bit replaces data with full-scale ramp.
// RQ9: Alternate bit toggles between both custom codes.
// RQ10: Constant bit outputs first custom code.
// RQ11: Register 0x26 high byte is first code.
// RQ12: Register 0x27 high byte is second code.
// RQ13: Register 0x2A holds four quad gain fields.
// RQ14: Host sets at most one pattern bit.
// RQ15: Unassigned bits read zero, ignore writes.
// RQ16: Word is 8 address then 16 data bits.
// RQ17: Commit on every 24th rising serial edge.
// RQ18: Host cycles power-down bit during start-up.
module acr_config_bank (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       serial_clock_i,
  input  wire logic       serial_config_input_i,
  input  wire logic       serial_config_select_n_i,
  input  wire logic       powerdown_input_pin_i,
  input  wire logic [7:0] conv_data_i,
  input  wire logic       sample_strobe_i,
  output logic      [3:0] quad_channel_nap_o,
  output logic      [1:0] dual_channel_nap_o,
  output logic            single_channel_nap_o,
  output logic            chip_sleep_o,
  output logic            full_power_off_request_o,
  output logic      [1:0] powerdown_pin_function_o,
  output logic            powerdown_pin_level_o,
  output logic      [2:0] bit_clock_drive_o,
  output logic      [2:0] frame_clock_drive_o,
  output logic      [2:0] data_drive_o,
  output logic            term_enable_o,
  output logic      [2:0] bit_clock_term_o,
  output logic      [2:0] frame_clock_term_o,
  output logic      [2:0] data_term_o,
  output logic      [3:0] quad_polarity_swap_o,
  output logic      [1:0] dual_polarity_swap_o,
  output logic            single_polarity_swap_o,
  output logic      [7:0] first_pattern_code_o,
  output logic      [7:0] second_pattern_code_o,
  output logic      [3:0] quad_gain_lane_one_o,
  output logic      [3:0] quad_gain_lane_two_o,
  output logic      [3:0] quad_gain_lane_three_o,
  output logic      [3:0] quad_gain_lane_four_o,
  output logic      [7:0] out_word_o,
  output logic            out_valid_o
);

  logic [15:0] power_sleep_control;
  logic [15:0] output_drive_strength;
  logic [15:0] output_termination;
  logic [15:0] input_polarity_swap;
  logic [15:0] test_pattern_select;
  logic [15:0] custom_code_first;
  logic [15:0] custom_code_second;
  logic [15:0] quad_coarse_gain;
  logic        sclk_prev;
  logic [22:0] shift;
  logic [4:0]  bit_count;
  logic [7:0]  ramp_value;
  logic        alt_second;
  logic        pin_level;

  // Serial clock is compared with its registered copy; a rise is seen in the first cycle the pin reads high.
  wire                  sclk_rise  = serial_clock_i && !sclk_prev;
  wire                  shift_en   = sclk_rise && !serial_config_select_n_i;
  wire                  last_bit   = bit_count == `ACR_LAST_BIT;
  wire                  commit     = shift_en && last_bit;
  wire [23:0]           word       = {shift, serial_config_input_i};
  wire [7:0]            wr_addr    = word[`ACR_ADDR_MSB:`ACR_ADDR_LSB];
  wire [15:0]           wr_data    = word[15:0];
  wire                  soft_reset = commit && wr_addr == `ACR_ADDR_SOFT_RESET
                                     && wr_data[`ACR_SOFT_RESET_BIT];
  wire                  clear_all  = reset_i || soft_reset;
  wire [4:0]            next_count = last_bit ? 5'h00 : bit_count + 5'h01;

  wire wr_power   = commit && wr_addr == `ACR_ADDR_POWER;
  wire wr_drive   = commit && wr_addr == `ACR_ADDR_DRIVE;
  wire wr_term    = commit && wr_addr == `ACR_ADDR_TERM;
  wire wr_swap    = commit && wr_addr == `ACR_ADDR_SWAP;
  wire wr_pattern = commit && wr_addr == `ACR_ADDR_PATTERN;
  wire wr_code1   = commit && wr_addr == `ACR_ADDR_CODE_ONE;
  wire wr_code2   = commit && wr_addr == `ACR_ADDR_CODE_TWO;
  wire wr_gain    = commit && wr_addr == `ACR_ADDR_GAIN;

  // Ramp wins over the two code modes if the host sets more than one bit.
  acr_pkg::acr_pat_t pat_mode;
  assign pat_mode = test_pattern_select[`ACR_PAT_RAMP_BIT] ? acr_pkg::PAT_RAMP : //RQ8
                    test_pattern_select[`ACR_PAT_ALT_BIT] ? acr_pkg::PAT_ALT :   //RQ9
                    test_pattern_select[`ACR_PAT_CONST_BIT] ? acr_pkg::PAT_CONST :
                    acr_pkg::PAT_NONE;                                          //RQ10

  logic [7:0] next_word;
  always_comb begin
    case (pat_mode)
      acr_pkg::PAT_RAMP:  next_word = ramp_value;
      acr_pkg::PAT_ALT:   next_word = alt_second ? second_pattern_code_o
                                                 : first_pattern_code_o;
      acr_pkg::PAT_CONST: next_word = first_pattern_code_o;
      default:            next_word = conv_data_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sclk_prev <= 1'b0;
      shift     <= 23'h000000;
      bit_count <= 5'h00;
    end else begin
      sclk_prev <= serial_clock_i;
      if (serial_config_select_n_i) begin
        bit_count <= 5'h00;
      end else if (shift_en) begin
        shift     <= word[22:0]; //RQ16
        bit_count <= next_count; //RQ17
      end
    end
  end

  // The soft reset bit is never stored, so it is clear after the write.
  always_ff @(posedge clk_i) begin
    if (clear_all) begin //RQ1
      power_sleep_control   <= `ACR_RST_POWER;
      output_drive_strength <= `ACR_RST_DRIVE;
      output_termination    <= `ACR_RST_TERM;
      input_polarity_swap   <= `ACR_RST_SWAP;
      test_pattern_select   <= `ACR_RST_PATTERN;
      custom_code_first     <= `ACR_RST_CODE;
      custom_code_second    <= `ACR_RST_CODE;
      quad_coarse_gain      <= `ACR_RST_GAIN;
    end else begin
      if (wr_power) power_sleep_control <= wr_data & `ACR_MASK_POWER; //RQ2 RQ3 RQ15
      if (wr_drive) output_drive_strength <= wr_data & `ACR_MASK_DRIVE; //RQ4
      if (wr_term) output_termination <= wr_data & `ACR_MASK_TERM; //RQ5 RQ6
      if (wr_swap) input_polarity_swap <= wr_data & `ACR_MASK_SWAP; //RQ7
      if (wr_pattern) test_pattern_select <= wr_data & `ACR_MASK_PATTERN;
      if (wr_code1) custom_code_first <= wr_data & `ACR_MASK_CODE; //RQ11
      if (wr_code2) custom_code_second <= wr_data & `ACR_MASK_CODE; //RQ12
      if (wr_gain) quad_coarse_gain <= wr_data & `ACR_MASK_GAIN; //RQ13
    end
  end

  // Pattern generator advances once per output word.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ramp_value  <= 8'h00;
      alt_second  <= 1'b0;
      out_word_o  <= 8'h00;
      out_valid_o <= 1'b0;
      pin_level   <= 1'b0;
    end else begin
      pin_level   <= powerdown_input_pin_i;
      out_valid_o <= sample_strobe_i;
      if (sample_strobe_i) begin
        out_word_o <= next_word;
        ramp_value <= (pat_mode == acr_pkg::PAT_RAMP) ? ramp_value + 8'h01 : 8'h00; //RQ8
        alt_second <= (pat_mode == acr_pkg::PAT_ALT) && !alt_second; //RQ9
      end
    end
  end

  assign quad_channel_nap_o       = power_sleep_control[3:0];
  assign dual_channel_nap_o       = power_sleep_control[5:4];
  assign single_channel_nap_o     = power_sleep_control[6];
  assign chip_sleep_o             = power_sleep_control[8];
  assign full_power_off_request_o = power_sleep_control[9];
  assign powerdown_pin_function_o = power_sleep_control[11:10];
  assign powerdown_pin_level_o    = pin_level;
  assign bit_clock_drive_o        = output_drive_strength[2:0];
  assign frame_clock_drive_o      = output_drive_strength[5:3];
  assign data_drive_o             = output_drive_strength[10:8];
  assign term_enable_o            = output_termination[`ACR_TERM_EN_BIT];
  assign bit_clock_term_o         = output_termination[2:0];
  assign frame_clock_term_o       = output_termination[5:3];
  assign data_term_o              = output_termination[10:8];
  assign quad_polarity_swap_o     = input_polarity_swap[3:0];
  assign dual_polarity_swap_o     = input_polarity_swap[5:4];
  assign single_polarity_swap_o   = input_polarity_swap[6];
  assign first_pattern_code_o     = custom_code_first[15:8];
  assign second_pattern_code_o    = custom_code_second[15:8];
  assign quad_gain_lane_one_o     = quad_coarse_gain[3:0];
  assign quad_gain_lane_two_o     = quad_coarse_gain[7:4];
  assign quad_gain_lane_three_o   = quad_coarse_gain[11:8];
  assign quad_gain_lane_four_o    = quad_coarse_gain[15:12];

  sequence write_to(logic [7:0] a);
    commit && wr_addr == a && !soft_reset;
  endsequence

  sequence ramp_word;
    sample_strobe_i && pat_mode == acr_pkg::PAT_RAMP;
  endsequence

  sequence alt_word(logic second);
    sample_strobe_i && pat_mode == acr_pkg::PAT_ALT && alt_second == second;
  endsequence

  soft_reset_clear_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ1
    soft_reset |=> power_sleep_control == `ACR_RST_POWER && quad_coarse_gain == `ACR_RST_GAIN
                   && test_pattern_select == `ACR_RST_PATTERN)
    else $error("soft reset did not restore defaults");

  power_write_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ2
    write_to(`ACR_ADDR_POWER) |=> quad_channel_nap_o == $past(wr_data[3:0])
                                  && single_channel_nap_o == $past(wr_data[6]))
    else $error("sleep bits not taken from write");

  pin_function_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ3
    write_to(`ACR_ADDR_POWER) |=> powerdown_pin_function_o == $past(wr_data[11:10]))
    else $error("pin function field wrong");

  drive_write_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ4
    write_to(`ACR_ADDR_DRIVE) |=> data_drive_o == $past(wr_data[10:8])
                                  && frame_clock_drive_o == $past(wr_data[5:3]))
    else $error("drive fields wrong");

  term_enable_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ5
    write_to(`ACR_ADDR_TERM) |=> term_enable_o == $past(wr_data[14])
                                 && data_term_o == $past(wr_data[10:8]))
    else $error("termination fields wrong");

  unused_zero_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ15
    (power_sleep_control & ~`ACR_MASK_POWER) == 16'h0000
    && (test_pattern_select & ~`ACR_MASK_PATTERN) == 16'h0000
    && custom_code_first[7:0] == 8'h00)
    else $error("unassigned bit set");

  ramp_step_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ8
    ramp_word ##1 ramp_word |=> out_word_o == $past(out_word_o) + 8'h01)
    else $error("ramp did not step by one");

  alt_toggle_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ9
    alt_word(1'b0) |=> out_word_o == first_pattern_code_o && alt_second)
    else $error("alternate pattern out of step");

  alt_second_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ9
    alt_word(1'b1) |=> out_word_o == second_pattern_code_o && !alt_second)
    else $error("second alternate word wrong");

  const_code_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ10
    sample_strobe_i && pat_mode == acr_pkg::PAT_CONST |=> out_word_o == first_pattern_code_o)
    else $error("constant code not shown");

  // A commit must sit on a real low-to-high step of the pin, seen inside select.
  word_commit_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ17
    commit |-> serial_clock_i && !$past(serial_clock_i) && !serial_config_select_n_i)
    else $error("commit off a selected serial rise");

  count_step_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ17
    shift_en && !commit |=> bit_count == $past(bit_count) + 5'h01)
    else $error("bit counter did not step");

  count_wrap_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ17
    commit |=> bit_count == 5'h00)
    else $error("bit counter did not wrap after a word");

  select_clear_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ17
    serial_config_select_n_i |=> bit_count == 5'h00)
    else $error("partial word kept after deselect");

  shift_order_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ16
    shift_en |=> shift[0] == $past(serial_config_input_i)
                 && shift[22:1] == $past(shift[21:0]))
    else $error("serial bit not shifted in at the rise");

  term_value_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ6
    write_to(`ACR_ADDR_TERM) |=> bit_clock_term_o == $past(wr_data[2:0])
                                 && frame_clock_term_o == $past(wr_data[5:3]))
    else $error("termination values wrong");

  swap_write_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ7
    write_to(`ACR_ADDR_SWAP) |=> quad_polarity_swap_o == $past(wr_data[3:0])
                                 && dual_polarity_swap_o == $past(wr_data[5:4])
                                 && single_polarity_swap_o == $past(wr_data[6]))
    else $error("polarity swap bits wrong");

  first_code_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ11
    write_to(`ACR_ADDR_CODE_ONE) |=> first_pattern_code_o == $past(wr_data[15:8]))
    else $error("first custom code wrong");

  second_code_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ12
    write_to(`ACR_ADDR_CODE_TWO) |=> second_pattern_code_o == $past(wr_data[15:8]))
    else $error("second custom code wrong");

  gain_write_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ13
    write_to(`ACR_ADDR_GAIN) |=> {quad_gain_lane_four_o, quad_gain_lane_three_o,
                                  quad_gain_lane_two_o, quad_gain_lane_one_o} == $past(wr_data))
    else $error("coarse gain fields wrong");

  // Registers may only move on a committed word, never on a stray serial edge.
  regs_hold_a: assert property (@(posedge clk_i) disable iff (reset_i) //RQ15
    !commit |=> $stable(power_sleep_control) && $stable(output_termination)
                && $stable(quad_coarse_gain))
    else $error("register changed without a write");

endmodule

// ===== src/acr_consts.svh
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// Serial word layout.
`define ACR_WORD_BITS       24
`define ACR_LAST_BIT        5'h17
`define ACR_ADDR_MSB        23
`define ACR_ADDR_LSB        16

// Register addresses.
`define ACR_ADDR_SOFT_RESET 8'h00
`define ACR_ADDR_POWER      8'h0F
`define ACR_ADDR_DRIVE      8'h11
`define ACR_ADDR_TERM       8'h12
`define ACR_ADDR_SWAP       8'h24
`define ACR_ADDR_PATTERN    8'h25
`define ACR_ADDR_CODE_ONE   8'h26
`define ACR_ADDR_CODE_TWO   8'h27
`define ACR_ADDR_GAIN       8'h2A

// Writable bits of each register; all other bits stay zero.
`define ACR_MASK_POWER      16'h0F7F
`define ACR_MASK_DRIVE      16'h073F
`define ACR_MASK_TERM       16'h473F
`define ACR_MASK_SWAP       16'h007F
`define ACR_MASK_PATTERN    16'h0070
`define ACR_MASK_CODE       16'hFF00
`define ACR_MASK_GAIN       16'hFFFF

// Reset values. Drive code 0 stands for 3.5 mA, gain code 0 for unity,
// pin function 0 for full power-down.
`define ACR_RST_POWER       16'h0000
`define ACR_RST_DRIVE       16'h0000
`define ACR_RST_TERM        16'h0000
`define ACR_RST_SWAP        16'h0000
`define ACR_RST_PATTERN     16'h0000
`define ACR_RST_CODE        16'h0000
`define ACR_RST_GAIN        16'h0000

// Field positions.
`define ACR_SOFT_RESET_BIT  0
`define ACR_TERM_EN_BIT     14
`define ACR_PAT_RAMP_BIT    6
`define ACR_PAT_ALT_BIT     5
`define ACR_PAT_CONST_BIT   4

`endif

// ===== src/acr_pkg.sv
package acr_pkg;
  typedef enum logic [1:0] {
    PAT_NONE,
    PAT_RAMP,
    PAT_ALT,
    PAT_CONST
  } acr_pat_t;
endpackage
